/* File: hw/acr_dev.sv */
// Purpose : Converter end: takes the control word, strobes, shifts the result
// Assumes : Serial clock from host, sampled on CLK; SAMPLE is the conversion value
// Notes   : Analog conversion is modelled as a capture of SAMPLE
// How it works
// - Host drives one active-high serial clock
// - Bits taken only while select is low
// - Word 1xxxxx11 starts external-clock conversion
// - Strobe falls when result is ready
// - Sixteen bits, one per clock rising edge
// - Fourteen result bits then two trailing bits
// - Deselect disables interface until next start
// - Output changes on falling serial clock edges
// - Result shifted most significant bit first
// - Unipolar straight binary, bipolar twos complement
// - Serial clock at most 2.1 MHz
`timescale 1ns/10ps
module acr_dev (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        BIPOLAR,
  input  wire logic [13:0] SAMPLE,
  output logic [4:0]       MODE_BITS,
  output logic             CONV_START,
  acr_if.dev               LINK
);
  typedef enum logic [1:0] {D_CMD, D_CONV, D_SHIFT, D_OFF} acr_dst_t;

  // ==========================================================
  // State and helper signals
  acr_dst_t    st_q;
  logic        sclk_s1_q, sclk_s2_q, sclk_s3_q;
  logic        sel_s1_q, sel_s2_q;
  logic        din_s1_q, din_s2_q;
  logic [7:0]  cmd_q;
  logic [3:0]  cnt_q;
  logic [15:0] sh_q;
  logic        strb_q;
  logic [4:0]  mode_q;
  logic        start_q;
  logic        rise;      // Serial clock rose, seen here
  logic        fall;      // Serial clock fell, seen here
  logic        sel;       // Select held, synchronised
  logic [13:0] code;      // Converted value in its output coding
  logic [7:0]  cmd_next;  // Command word with the new bit in
  logic        cmd_take;  // Take one command bit now
  logic        start_hit; // Start word complete
  logic        conv_done; // Conversion time over
  logic        shift_out; // Next result bit to the pin
  logic        last_bit;  // Sixteenth bit taken by the host

  // ==========================================================
  // Input synchronisers
  // Three cycles of lag are small against a serial half period
  // Serial clock; third stage only for edge finding
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
    end else begin
      sclk_s1_q <= LINK.sclk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
    end
  end

  // Select resets released, so nothing is taken before the host asks
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sel_s1_q <= 1'b1;
      sel_s2_q <= 1'b1;
    end else begin
      sel_s1_q <= LINK.sel_n;
      sel_s2_q <= sel_s1_q;
    end
  end

  // Command data settles a half period before the rise that takes it
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      din_s1_q <= 1'b0;
      din_s2_q <= 1'b0;
    end else begin
      din_s1_q <= LINK.din;
      din_s2_q <= din_s1_q;
    end
  end

  // Edge finders on the settled clock copy
  assign rise = sclk_s2_q && !sclk_s3_q;
  assign fall = !sclk_s2_q && sclk_s3_q;
  assign sel  = !sel_s2_q;

  // Bipolar code flips MSB of an offset sample into twos complement
  assign code = BIPOLAR ? {~SAMPLE[13], SAMPLE[12:0]} : SAMPLE;

  // ==========================================================
  // Frame decode
  // Every event is gated by select, so a deselect cuts any frame
  // Command word is cleared on deselect, so a start needs all 8 bits
  assign cmd_next  = {cmd_q[6:0], din_s2_q};
  assign cmd_take  = sel && (st_q == D_CMD) && rise;
  assign start_hit = cmd_take && acr_pkg::acr_is_start(cmd_next);
  assign conv_done = sel && (st_q == D_CONV) && fall && (cnt_q == acr_pkg::CONV_LAST);
  assign shift_out = sel && (st_q == D_SHIFT) && fall && (cnt_q != 4'h0);
  assign last_bit  = sel && (st_q == D_SHIFT) && rise && (cnt_q == acr_pkg::FRAME_LAST[3:0]);

  // ==========================================================
  // Frame sequencer
  // State register; deselect always wins so a cut frame re-arms
  // Once off, only a deselect brings the command stage back
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_q <= D_CMD;
    end else if (!sel) begin
      st_q <= D_CMD;
    end else begin
      unique case (st_q)
        D_CMD: if (start_hit) begin
          st_q <= D_CONV;
        end
        D_CONV: if (conv_done) begin
          st_q <= D_SHIFT;
        end
        D_SHIFT: if (last_bit) begin
          st_q <= D_OFF;
        end
        D_OFF: st_q <= D_OFF;
      endcase
    end
  end

  // Command shifter, MSB first
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cmd_q <= 8'h00;
    end else if (!sel || st_q == D_OFF) begin
      cmd_q <= 8'h00;
    end else if (cmd_take) begin
      cmd_q <= cmd_next;
    end
  end

  // Counts serial falls while converting, then rises while reading
  // One counter serves both phases since they never overlap
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cnt_q <= 4'h0;
    end else if (!sel || start_hit || conv_done) begin
      cnt_q <= 4'h0;
    end else if (fall && st_q == D_CONV) begin
      cnt_q <= cnt_q + 4'h1;
    end else if (rise && st_q == D_SHIFT) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // Result shifter; first bit stands before the first rise
  // Moves only on falls, so the host's rise always sees a settled bit
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sh_q <= 16'h0000;
    end else if (conv_done) begin
      sh_q <= {code, {acr_pkg::TRAIL_BITS{1'b0}}};
    end else if (shift_out) begin
      sh_q <= {sh_q[14:0], 1'b0};
    end
  end

  // Strobe falls with the first result bit
  // Back high at the first read rise, ready for the next frame
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      strb_q <= 1'b1;
    end else if (!sel) begin
      strb_q <= 1'b1;
    end else if (conv_done) begin
      strb_q <= 1'b0;
    end else if (rise && st_q == D_SHIFT) begin
      strb_q <= 1'b1;
    end
  end

  // Middle bits of the last start word
  // Kept across deselect so user logic may read them late
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mode_q <= acr_pkg::CTRL_MID_RST;
    end else if (start_hit) begin
      mode_q <= cmd_next[acr_pkg::CTRL_START_POS-1:acr_pkg::CTRL_EXT1_POS+1];
    end
  end

  // One-cycle pulse as a conversion begins
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start_hit;
    end
  end

  // ==========================================================
  // Outputs, all straight from flops
  // Result pin keeps its last bit while deselected; host ignores it
  assign LINK.dout              = sh_q[15];
  assign LINK.conversion_strobe = strb_q;
  assign MODE_BITS              = mode_q;
  assign CONV_START             = start_q;
endmodule : acr_dev

/* File: hw/acr_pkg.sv */
// Purpose : Shared constants for the external-clock serial conversion link
// Assumes : One 250 MHz system clock at each end; serial clock made by the host
// Notes   : Link clock is sampled, never used as a clock
package acr_pkg;

  // ==========================================================
  // Control word
  localparam int          CTRL_BITS      = 8;
  localparam int          CTRL_START_POS = 7;
  localparam int          CTRL_EXT0_POS  = 0;
  localparam int          CTRL_EXT1_POS  = 1;
  localparam logic [4:0]  CTRL_MID_RST   = 5'h00;

  // ==========================================================
  // Result frame
  localparam int          RES_BITS       = 14;
  localparam int          FRAME_BITS     = 16;
  localparam int          TRAIL_BITS     = FRAME_BITS - RES_BITS;
  localparam logic [4:0]  FRAME_LAST     = 5'h0F;

  // ==========================================================
  // Timing
  localparam int          SYS_CLK_HZ     = 250_000_000;
  localparam int          SCLK_MAX_KHZ   = 2100;
  // Half period in system cycles, rounded up so the clock stays under the limit
  localparam int          SCLK_HALF_CYC  =
    (SYS_CLK_HZ + 2 * SCLK_MAX_KHZ * 1000 - 1) / (2 * SCLK_MAX_KHZ * 1000);
  localparam int          DIV_BITS       = 8;
  // Time the converter spends before the strobe falls, in serial clocks
  localparam int          CONV_SCLKS     = 2;
  localparam logic [3:0]  CONV_LAST      = 4'(CONV_SCLKS - 1);

  // ==========================================================
  // Pure decode used by the converter end
  function automatic logic acr_is_start(input logic [CTRL_BITS-1:0] w);
    return w[CTRL_START_POS] & w[CTRL_EXT1_POS] & w[CTRL_EXT0_POS];
  endfunction : acr_is_start

endpackage : acr_pkg

/* File: hw/acr_if.sv */
// Purpose : Five-wire serial link between host and converter
// Assumes : All lines are driven push-pull by one party
// Notes   : No clocking block; testbench joins both ends here
`timescale 1ns/10ps
interface acr_if;
  // ==========================================================
  // Link wires
  logic sclk;             // Serial clock from host
  logic sel_n;            // Device select, active low
  logic din;              // Host to converter
  logic dout;             // Converter to host
  logic conversion_strobe; // Falls when result is ready

  modport dev  (input sclk, input sel_n, input din, output dout, output conversion_strobe);
  modport host (output sclk, output sel_n, output din, input dout, input conversion_strobe);
endinterface : acr_if

/* File: hw/acr_host.sv */
// Purpose : Host end: starts one conversion and reads its 14-bit result
// Assumes : START pulse from user logic on CLK; converter on the link
// Notes   : Serial clock derived from CLK by a divider and driven out
`timescale 1ns/10ps
module acr_host (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        START,
  input  wire logic [4:0]  MODE_BITS,
  output logic             BUSY,
  output logic             DONE,
  output logic [13:0]      RESULT,
  acr_if.host              LINK
);
  typedef enum logic [2:0] {H_IDLE, H_CMD, H_WAIT, H_READ, H_END} acr_hst_t;

  acr_hst_t                       st_q;
  logic [acr_pkg::DIV_BITS-1:0]   div_q;
  logic                           sclk_q;
  logic [4:0]                     cnt_q;
  logic [acr_pkg::CTRL_BITS-1:0]  cmd_q;
  logic [acr_pkg::FRAME_BITS-1:0] sh_q;
  logic                           sel_n_q;
  logic                           done_q;
  logic [13:0]                    res_q;
  logic                           strb_s1_q, strb_s2_q, strb_s3_q;
  logic                           dout_s1_q, dout_s2_q;
  logic                           tick, rise, fall, run;

  // ==========================================================
  // Serial clock divider, free only while a frame is active
  assign run  = (st_q != H_IDLE); // Runs on through the last high phase, no runt pulse
  assign tick = run && (div_q == 8'(acr_pkg::SCLK_HALF_CYC - 1));
  assign rise = tick && !sclk_q;
  assign fall = tick && sclk_q;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      div_q  <= 8'h00;
      sclk_q <= 1'b0;
    end else if (!run) begin
      div_q  <= 8'h00;
      sclk_q <= 1'b0;
    end else if (tick) begin
      div_q  <= 8'h00;
      sclk_q <= ~sclk_q;
    end else begin
      div_q  <= div_q + 8'h01;
    end
  end

  // Synchronisers for converter outputs
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      strb_s1_q <= 1'b1;
      strb_s2_q <= 1'b1;
      strb_s3_q <= 1'b1;
      dout_s1_q <= 1'b0;
      dout_s2_q <= 1'b0;
    end else begin
      strb_s1_q <= LINK.conversion_strobe;
      strb_s2_q <= strb_s1_q;
      strb_s3_q <= strb_s2_q;
      dout_s1_q <= LINK.dout;
      dout_s2_q <= dout_s1_q;
    end
  end

  // ==========================================================
  // Sequencer: select, command, wait strobe, read 16, deselect
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_q    <= H_IDLE;
      cnt_q   <= 5'h00;
      cmd_q   <= 8'h00;
      sh_q    <= 16'h0000;
      sel_n_q <= 1'b1;
    end else begin
      unique case (st_q)
        H_IDLE: if (START) begin
          sel_n_q <= 1'b0;
          cmd_q   <= {1'b1, MODE_BITS, 2'b11};
          cnt_q   <= 5'h00;
          st_q    <= H_CMD;
        end
        H_CMD: if (fall && cnt_q != 5'h00) begin
          cmd_q <= {cmd_q[6:0], 1'b0};
        end else if (rise) begin
          if (cnt_q == 5'(acr_pkg::CTRL_BITS - 1)) begin
            st_q <= H_WAIT;
          end
          cnt_q <= cnt_q + 5'h01;
        end
        H_WAIT: if (!strb_s2_q && strb_s3_q) begin
          cnt_q <= 5'h00;
          st_q  <= H_READ;
        end
        H_READ: if (rise) begin
          sh_q  <= {sh_q[14:0], dout_s2_q};
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == acr_pkg::FRAME_LAST) begin
            st_q <= H_END;
          end
        end
        H_END: if (fall) begin
          sel_n_q <= 1'b1;
          st_q    <= H_IDLE;
        end
      endcase
    end
  end

  // Result latch drops the trailing bits
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      res_q  <= 14'h0000;
      done_q <= 1'b0;
    end else begin
      done_q <= (st_q == H_END) && fall;
      if ((st_q == H_END) && fall) begin
        res_q <= sh_q[acr_pkg::FRAME_BITS-1 -: acr_pkg::RES_BITS];
      end
    end
  end

  assign LINK.sclk  = sclk_q;
  assign LINK.sel_n = sel_n_q;
  assign LINK.din   = cmd_q[acr_pkg::CTRL_BITS-1];
  assign BUSY       = (st_q != H_IDLE);
  assign DONE       = done_q;
  assign RESULT     = res_q;
endmodule : acr_host

/* File: verification/acr_link_assertions.sv */
// Purpose : Checker on the wires between host end and converter end
// Assumes : One CLK domain, RST async active high
// Notes   : Serial clock is sampled on CLK, as the converter end does
`timescale 1ns/10ps
module acr_link_assertions (
  input wire logic CLK,
  input wire logic RST,
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic din,
  input wire logic dout,
  input wire logic conversion_strobe
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // ==========================================================
  // Helper counters
  logic       sclk_q;
  logic [4:0] rd_q;
  logic [4:0] wr_q;
  // Last serial clock level, for rise detection
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) sclk_q <= 1'b0;
    else sclk_q <= sclk;
  end
  // Rises since strobe fell; saturates so it never wraps
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) rd_q <= 5'h00;
    else if ($fell(conversion_strobe)) rd_q <= 5'h00;
    else if (sclk && !sclk_q && rd_q != 5'h1F) rd_q <= rd_q + 5'h01;
  end
  // Rises since select went low
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) wr_q <= 5'h00;
    else if (sel_n) wr_q <= 5'h00;
    else if (sclk && !sclk_q && wr_q != 5'h1F) wr_q <= wr_q + 5'h01;
  end
  // ==========================================================
  // Properties
  sequence s_read_begin;
    ##[1:130] $rose(sclk);
  endsequence
  sel_frame_a: assert property ($rose(sclk) |-> !sel_n)
    else $error("serial clock rose while deselected");
  sel_hold_a: assert property ($fell(sel_n) |-> (!sel_n)[*8])
    else $error("select released too soon");
  din_steady_a: assert property (sclk && $past(sclk) && !sel_n |-> $stable(din))
    else $error("command bit moved while clock high");
  sclk_high_a: assert property ($rose(sclk) |-> sclk[*8])
    else $error("serial clock high phase too short");
  dout_fall_a: assert property ($changed(dout) && !sel_n |-> !sclk)
    else $error("result bit moved while clock high");
  strobe_sel_a: assert property ($fell(conversion_strobe) |-> !sel_n)
    else $error("strobe fell while deselected");
  strobe_idle_a: assert property (sel_n |-> conversion_strobe)
    else $error("strobe low while deselected");
  read_begin_a: assert property ($fell(conversion_strobe) |-> s_read_begin)
    else $error("no clock rise after strobe fell");
  read_count_a: assert property ($rose(sel_n) |-> rd_q == 5'h10)
    else $error("readout rise count not sixteen");
  start_count_a: assert property ($fell(conversion_strobe) |-> wr_q inside {[5'h08:5'h0A]})
    else $error("strobe before eight command bits");
endmodule : acr_link_assertions

/* File: verification/testbench.sv */
// Purpose : Self-checking bench joining host end and converter end
// Assumes : 250 MHz CLK, RST held six cycles
// Notes   : Wire monitor rebuilds command and result frames
`timescale 1ns/10ps
module testbench;
  logic        clk, rst, start, bipolar, busy, done, conv_start;
  logic        sclk_p, stb_p, sel_p, got_stb;
  logic [4:0]  mode;
  logic [4:0]  dev_mode;
  logic [13:0] sample;
  logic [13:0] result;
  logic [15:0] dout_sh;
  logic [7:0]  din_sh;
  int          din_cnt, dout_cnt, conv_cnt, bad_count, comparisons;
  // ==========================================================
  // Both ends on one link
  acr_if   link ();
  acr_host u_acr_host (.CLK(clk), .RST(rst), .START(start), .MODE_BITS(mode), .BUSY(busy),
    .DONE(done), .RESULT(result), .LINK(link));
  acr_dev  u_acr_dev (.CLK(clk), .RST(rst), .BIPOLAR(bipolar), .SAMPLE(sample),
    .MODE_BITS(dev_mode), .CONV_START(conv_start), .LINK(link));
  acr_link_assertions u_acr_link_assertions (.CLK(clk), .RST(rst), .sclk(link.sclk),
    .sel_n(link.sel_n), .din(link.din), .dout(link.dout),
    .conversion_strobe(link.conversion_strobe));
  always #2 clk = ~clk;
  // Wire monitor: command bits before strobe, result bits after
  always @(posedge clk) begin
    sclk_p <= link.sclk;
    stb_p <= link.conversion_strobe;
    sel_p <= link.sel_n;
    if (conv_start === 1'b1) conv_cnt <= conv_cnt + 1;
    if (!link.sel_n && sel_p) begin
      din_cnt <= 0;
      dout_cnt <= 0;
      got_stb <= 1'b0;
    end else if (link.sclk && !sclk_p && !link.sel_n) begin
      if (got_stb) begin
        dout_sh <= {dout_sh[14:0], link.dout};
        dout_cnt <= dout_cnt + 1;
      end else if (din_cnt < 8) begin
        din_sh <= {din_sh[6:0], link.din};
        din_cnt <= din_cnt + 1;
      end
    end
    if (!link.conversion_strobe && stb_p) got_stb <= 1'b1;
  end
  // Bipolar coding is offset binary with its top bit turned over
  function automatic logic [13:0] exp_code(input logic bp, input logic [13:0] s);
    return bp ? (s ^ 14'h2000) : s;
  endfunction : exp_code
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // One conversion; hold keeps START up while busy, which must be ignored
  task automatic run_frame(input logic [4:0] m, input logic bp, input logic [13:0] s,
                           input logic hold);
    int          n;
    int          c0;
    logic [13:0] e;
    c0 = conv_cnt;
    e = exp_code(bp, s);
    @(posedge clk);
    mode <= m;
    bipolar <= bp;
    sample <= s;
    start <= 1'b1;
    if (hold) repeat (3) @(posedge clk);
    @(posedge clk);
    start <= 1'b0;
    @(negedge clk);
    check("busy high", 16'h0001, 16'(busy));
    n = 0;
    while (done !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 20000) check("done", 16'h0001, 16'(done));
    check("result", 16'(e), 16'(result));
    check("dev mode", 16'(m), 16'(dev_mode));
    check("command word", 16'({1'b1, m, 2'b11}), 16'(din_sh));
    check("serial frame", {e, 2'b00}, dout_sh);
    check("result bits", 16'h0010, 16'(dout_cnt));
    check("conversions", 16'h0001, 16'(conv_cnt - c0));
    repeat (2) @(negedge clk);
    check("busy low", 16'h0000, 16'(busy));
    $display("Frame done mode %h sample %h bipolar %b", m, s, bp);
  endtask : run_frame
  // ==========================================================
  // Corner cases first, then random frames
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    start = 1'b0;
    mode = 5'h00;
    bipolar = 1'b0;
    sample = 14'h0000;
    {sclk_p, stb_p, sel_p, got_stb} = 4'h6; // Idle levels, no false edge
    {din_cnt, dout_cnt, conv_cnt, bad_count, comparisons} = '0;
    {dout_sh, din_sh} = 24'h000000;
    void'($urandom(78));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    run_frame(5'h00, 1'b0, 14'h0000, 1'b0);
    run_frame(5'h1F, 1'b1, 14'h3FFF, 1'b1);
    run_frame(5'h15, 1'b1, 14'h0000, 1'b0);
    for (int i = 0; i < 5; i++)
      run_frame(5'($urandom), 1'($urandom), 14'($urandom), 1'b0);
    tally_and_finish();
  end
  // Watchdog well beyond eight frames of about 3000 cycles
  initial begin
    #300000;
    bad_count++;
    $display("Error watchdog expected finish seen hang");
    tally_and_finish();
  end
endmodule : testbench
